/* File: pkg/plsc_defines.vh */
`ifndef PLSC_DEFINES_VH
`define PLSC_DEFINES_VH
// ==========================================================
// register byte offsets
`define PLSC_OFS_MODE     8'h00
`define PLSC_OFS_ARITH    8'h04
`define PLSC_OFS_LUT0     8'h08
`define PLSC_OFS_LUT_LAST 8'h24
`define PLSC_OFS_STATUS   8'h28
// ==========================================================
// mode register fields
`define PLSC_MODE_W       2
`define PLSC_MODE_BITS    8
`define PLSC_SPLIT_BIT    8
`define PLSC_DONE_BIT     16
// ==========================================================
// slice modes
`define PLSC_M_LOGIC      2'h0
`define PLSC_M_ARITH      2'h1
`define PLSC_M_RAM        2'h2
`define PLSC_M_ROM        2'h3
// ==========================================================
// arith register fields
`define PLSC_OP_W         3
`define PLSC_FAST_LSB     12
// ==========================================================
// arithmetic operations
`define PLSC_OP_ADD       3'h0
`define PLSC_OP_SUB       3'h1
`define PLSC_OP_ADDSUB    3'h2
`define PLSC_OP_CNT       3'h3
`define PLSC_OP_CMP       3'h4
`define PLSC_OP_MULT      3'h5
// ==========================================================
// geometry and reset values
`define PLSC_SLICES       4
`define PLSC_LUTS         8
`define PLSC_TT_W         16
`define PLSC_MODE_RST     8'h00
`define PLSC_ARITH_RST    16'h0000
`define PLSC_TT_RST       16'h0000
`define PLSC_CNT_RST      2'h0
`endif

/* File: hdl/plsc_cluster.v */
// Functional notes
// - slices 0-2 take four modes; slice 3 no RAM
// - logic mode: each LUT is a 16-entry table
// - two LUTs per slice combine into five inputs
// - wider functions chain slices; eight inputs need more
// - 2-bit add, subtract, or dynamic add/subtract
// - 2-bit counters, async clear, sync preload
// - compare A and B: ge, ne, le
// - slice works as multiplier building block
// - fast carry: generate and propagate per slice
// - slices 0 and 1 store 16x2 each
// - slice 2 supplies address and write control
// - split port: one read-write, one read-only slice
// - writes update both split-port copies together
// - memory starts from user-defined contents
// - 16x4 one-port three slices; split 16x2 also three
// - ROM mode in all four slices
// - ROM contents loaded only at configuration
`timescale 1ns/1ps
`include "plsc_defines.vh"

module plsc_cluster (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [31:0] usr_lut_in,
  input  wire [3:0]  usr_f5_sel,
  input  wire [1:0]  usr_f6_sel,
  input  wire        usr_f7_sel,
  input  wire        usr_f8_sel,
  input  wire        usr_f7_ext,
  output wire [7:0]  usr_f,
  output wire [3:0]  usr_f5,
  output wire [1:0]  usr_f6,
  output wire        usr_f7,
  output wire        usr_f8,
  input  wire [7:0]  usr_arith_a,
  input  wire [7:0]  usr_arith_b,
  input  wire        usr_cin,
  input  wire [3:0]  usr_addsub,
  input  wire [3:0]  usr_cnt_en,
  input  wire [3:0]  usr_cnt_up,
  input  wire [3:0]  usr_cnt_clr,
  input  wire [3:0]  usr_cnt_load,
  output wire [7:0]  usr_arith_s,
  output wire        usr_cout,
  output wire [3:0]  usr_cg,
  output wire [3:0]  usr_cp,
  output wire [3:0]  usr_ge,
  output wire [3:0]  usr_ne,
  output wire [3:0]  usr_le,
  input  wire [3:0]  usr_ram_addr,
  input  wire [3:0]  usr_ram_raddr,
  input  wire [3:0]  usr_ram_wdata,
  input  wire        usr_ram_we,
  output wire [3:0]  usr_ram_rdata,
  output wire [1:0]  usr_ram_rdata2
);

  // ==========================================================
  // functions
  function lut4;
    input [15:0] tt;
    input [3:0]  sel;
    begin
      lut4 = tt[sel];
    end
  endfunction

  function [3:0] lut_index;
    input [7:0] addr;
    reg   [7:0] off;
    begin
      off       = addr - `PLSC_OFS_LUT0;
      lut_index = off[5:2];
    end
  endfunction

  function is_lut_addr;
    input [7:0] addr;
    begin
      is_lut_addr = (addr >= `PLSC_OFS_LUT0) && (addr <= `PLSC_OFS_LUT_LAST) &&
                    (addr[1:0] == 2'h0);
    end
  endfunction

  // ==========================================================
  // configuration registers
  reg [7:0]  mode_reg;
  reg        split_reg;
  reg        done_reg;
  reg [15:0] arith_reg;
  reg [15:0] tt_reg [0:7];
  wire [7:0] cnt_all;

  wire       apb_wr   = psel & penable & pwrite;
  wire       cfg_open = ~done_reg;
  wire [3:0] wr_idx   = lut_index(paddr);
  wire       known    = (paddr == `PLSC_OFS_MODE) || (paddr == `PLSC_OFS_ARITH) ||
                        (paddr == `PLSC_OFS_STATUS) || is_lut_addr(paddr);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // ==========================================================
  // mode and arith registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= `PLSC_MODE_RST;
      split_reg <= 1'b0;
      done_reg  <= 1'b0;
      arith_reg <= `PLSC_ARITH_RST;
    end else if (apb_wr && cfg_open && paddr == `PLSC_OFS_MODE) begin
      mode_reg[5:0] <= pwdata[5:0];
      if (pwdata[7:6] != `PLSC_M_RAM) begin
        mode_reg[7:6] <= pwdata[7:6];
      end
      split_reg <= pwdata[`PLSC_SPLIT_BIT];
      done_reg  <= pwdata[`PLSC_DONE_BIT];
    end else if (apb_wr && cfg_open && paddr == `PLSC_OFS_ARITH) begin
      arith_reg <= pwdata[15:0];
    end
  end

  // ==========================================================
  // distributed memory control
  wire [1:0] m0 = mode_reg[1:0];
  wire [1:0] m1 = mode_reg[3:2];
  wire [1:0] m2 = mode_reg[5:4];
  wire       ram_one = (m0 == `PLSC_M_RAM) && (m1 == `PLSC_M_RAM) &&
                       (m2 == `PLSC_M_RAM) && ~split_reg;
  wire       ram_two = (m0 == `PLSC_M_RAM) && (m1 == `PLSC_M_RAM) &&
                       (m2 == `PLSC_M_RAM) && split_reg;
  wire       ram_we  = usr_ram_we & done_reg & (ram_one | ram_two);
  wire [1:0] hi_data = ram_two ? usr_ram_wdata[1:0] : usr_ram_wdata[3:2];
  wire [3:0] ram_bit = {hi_data, usr_ram_wdata[1:0]};

  // ==========================================================
  // truth tables: apb load before lock, ram writes after
  genvar g;
  always @(posedge pclk or negedge presetn) begin : tt_upd
    integer i;
    if (!presetn) begin
      for (i = 0; i < `PLSC_LUTS; i = i + 1) begin
        tt_reg[i] <= `PLSC_TT_RST;
      end
    end else if (apb_wr && cfg_open && is_lut_addr(paddr)) begin
      tt_reg[wr_idx[2:0]] <= pwdata[15:0];
    end else if (ram_we) begin
      for (i = 0; i < `PLSC_SLICES; i = i + 1) begin
        tt_reg[i][usr_ram_addr] <= ram_bit[i];
      end
    end
  end

  // ==========================================================
  // memory read ports
  assign usr_ram_rdata[0] = lut4(tt_reg[0], usr_ram_addr);
  assign usr_ram_rdata[1] = lut4(tt_reg[1], usr_ram_addr);
  assign usr_ram_rdata[2] = ram_two ? 1'b0 : lut4(tt_reg[2], usr_ram_addr);
  assign usr_ram_rdata[3] = ram_two ? 1'b0 : lut4(tt_reg[3], usr_ram_addr);
  assign usr_ram_rdata2[0] = ram_two ? lut4(tt_reg[2], usr_ram_raddr) : 1'b0;
  assign usr_ram_rdata2[1] = ram_two ? lut4(tt_reg[3], usr_ram_raddr) : 1'b0;

  // ==========================================================
  // logic and rom: lut outputs and wide muxes
  generate
    for (g = 0; g < `PLSC_LUTS; g = g + 1) begin : g_lut
      assign usr_f[g] = lut4(tt_reg[g], usr_lut_in[4*g+3:4*g]);
    end
    for (g = 0; g < `PLSC_SLICES; g = g + 1) begin : g_f5
      assign usr_f5[g] = usr_f5_sel[g] ? usr_f[2*g+1] : usr_f[2*g];
    end
  endgenerate

  assign usr_f6[0] = usr_f6_sel[0] ? usr_f5[1] : usr_f5[0];
  assign usr_f6[1] = usr_f6_sel[1] ? usr_f5[3] : usr_f5[2];
  assign usr_f7    = usr_f7_sel ? usr_f6[1] : usr_f6[0];
  assign usr_f8    = usr_f8_sel ? usr_f7_ext : usr_f7;

  // ==========================================================
  // arithmetic slices
  wire [4:0] carry;
  assign carry[0] = usr_cin;
  assign usr_cout = carry[4];

  generate
    for (g = 0; g < `PLSC_SLICES; g = g + 1) begin : g_ar
      wire [2:0] op    = arith_reg[3*g+2:3*g];
      wire       fast  = arith_reg[`PLSC_FAST_LSB+g];
      wire       on    = (mode_reg[2*g+1:2*g] == `PLSC_M_ARITH);
      wire [1:0] a     = usr_arith_a[2*g+1:2*g];
      wire [1:0] b     = usr_arith_b[2*g+1:2*g];
      wire       sub   = (op == `PLSC_OP_SUB) ||
                         (op == `PLSC_OP_ADDSUB && usr_addsub[g]);
      wire [1:0] pp    = a & {2{usr_addsub[g]}};
      wire [1:0] x     = (op == `PLSC_OP_MULT) ? pp : a;
      wire [1:0] y     = sub ? ~b : b;
      wire [2:0] sum   = {1'b0, x} + {1'b0, y} + {2'b00, carry[g]};
      wire       gen   = (x[1] & y[1]) | ((x[1] ^ y[1]) & x[0] & y[0]);
      wire       prop  = (x[1] ^ y[1]) & (x[0] ^ y[0]);
      wire       co_f  = gen | (prop & carry[g]);
      reg  [1:0] cnt_reg;
      wire [1:0] cnt   = cnt_reg;
      assign cnt_all[2*g+1:2*g] = cnt_reg;
      assign carry[g+1] = ~on ? carry[g] : (fast ? co_f : sum[2]);
      assign usr_cg[g] = on & fast & gen;
      assign usr_cp[g] = on & fast & prop;
      assign usr_arith_s[2*g+1:2*g] = ~on ? 2'h0 :
                                      (op == `PLSC_OP_CNT) ? cnt : sum[1:0];
      assign usr_ge[g] = on & (op == `PLSC_OP_CMP) & (a >= b);
      assign usr_ne[g] = on & (op == `PLSC_OP_CMP) & (a != b);
      assign usr_le[g] = on & (op == `PLSC_OP_CMP) & (a <= b);

      // counter: async clear, sync preload over count
      always @(posedge pclk or negedge presetn or posedge usr_cnt_clr[g]) begin
        if (!presetn) begin
          cnt_reg <= `PLSC_CNT_RST;
        end else if (usr_cnt_clr[g]) begin
          cnt_reg <= `PLSC_CNT_RST;
        end else if (on && op == `PLSC_OP_CNT && usr_cnt_load[g]) begin
          cnt_reg <= a;
        end else if (on && op == `PLSC_OP_CNT && usr_cnt_en[g]) begin
          cnt_reg <= usr_cnt_up[g] ? cnt + 2'h1 : cnt - 2'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // apb read data, captured in setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `PLSC_OFS_MODE) begin
        prdata <= {15'h0000, done_reg, 7'h00, split_reg, mode_reg};
      end else if (paddr == `PLSC_OFS_ARITH) begin
        prdata <= {16'h0000, arith_reg};
      end else if (paddr == `PLSC_OFS_STATUS) begin
        prdata <= {23'h000000, done_reg, cnt_all};
      end else if (is_lut_addr(paddr)) begin
        prdata <= {16'h0000, tt_reg[wr_idx[2:0]]};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // plsc_cluster

/* File: bench/plsc_cluster_chk.sv */
`timescale 1ns/1ps
// ==========
// port checker
module plsc_cluster_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  usr_f,
  input wire [3:0]  usr_f5_sel,
  input wire [3:0]  usr_f5,
  input wire [1:0]  usr_f6_sel,
  input wire [1:0]  usr_f6,
  input wire        usr_f7_sel,
  input wire        usr_f7,
  input wire        usr_f8_sel,
  input wire        usr_f7_ext,
  input wire        usr_f8,
  input wire [3:0]  usr_ge,
  input wire [3:0]  usr_ne,
  input wire [3:0]  usr_le,
  input wire [3:0]  usr_cg,
  input wire [3:0]  usr_cp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (pready) else $error("pready low");
  AST_ERR: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
    else $error("no error on unmapped");
  AST_OK: assert property (psel && penable && paddr < 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  AST_RST: assert property ($rose(presetn) |-> prdata == 32'h0 && usr_f == 8'h00)
    else $error("not clear after reset");
  AST_F5: assert property (usr_f5[0] == (usr_f5_sel[0] ? usr_f[1] : usr_f[0]))
    else $error("f5 mux");
  AST_F6: assert property (usr_f6[1] == (usr_f6_sel[1] ? usr_f5[3] : usr_f5[2]))
    else $error("f6 mux");
  AST_F7: assert property (usr_f7 == (usr_f7_sel ? usr_f6[1] : usr_f6[0]))
    else $error("f7 mux");
  AST_F8: assert property (usr_f8 == (usr_f8_sel ? usr_f7_ext : usr_f7))
    else $error("f8 mux");
  AST_CMP: assert property ((usr_ge & usr_le & usr_ne) == 4'h0)
    else $error("compare flags clash");
  AST_GP: assert property ((usr_cg & usr_cp) == 4'h0)
    else $error("generate and propagate both high");
  cover property (psel && penable && pslverr);
  cover property (usr_f8_sel && usr_f8);
  cover property (usr_ne[3] && usr_ge[3]);
endmodule // plsc_cluster_chk

bind plsc_cluster plsc_cluster_chk plsc_cluster_chk_i (.*);

/* File: bench/plsc_fabric_model.sv */
`timescale 1ns/1ps
// ==========
// user fabric: fresh operands after every rising edge
module plsc_fabric_model (
  input  wire        pclk,
  output reg  [31:0] usr_lut_in = 32'h0,
  output reg  [7:0]  usr_arith_a = 8'h0,
  output reg  [7:0]  usr_arith_b = 8'h0,
  output reg  [3:0]  usr_addsub = 4'h0,
  output reg  [3:0]  usr_f5_sel = 4'h0,
  output reg  [1:0]  usr_f6_sel = 2'h0,
  output reg         usr_f7_sel = 1'b0,
  output reg         usr_f8_sel = 1'b0,
  output reg         usr_f7_ext = 1'b0,
  output reg         usr_cin = 1'b0
);
  always @(posedge pclk) begin
    usr_lut_in <= $urandom;
    {usr_arith_a, usr_arith_b, usr_addsub, usr_f5_sel, usr_f6_sel} <= 26'($urandom);
    {usr_f7_sel, usr_f8_sel, usr_f7_ext, usr_cin} <= 4'($urandom);
  end
endmodule // plsc_fabric_model

/* File: bench/plsc_cluster_tb.sv */
`timescale 1ns/1ps
`include "plsc_defines.vh"
// ==========
// cluster bench
module plsc_cluster_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 8'h0, usr_f, usr_arith_a, usr_arith_b, usr_arith_s;
  logic [31:0] pwdata = 32'h0, prdata, usr_lut_in, rd;
  logic [15:0] tt [8];
  logic [3:0]  mem [16];
  logic [3:0]  usr_f5_sel, usr_f5, usr_addsub, usr_cg, usr_cp, usr_ge, usr_ne, usr_le;
  logic [3:0]  usr_cnt_en = 0, usr_cnt_up = 0, usr_cnt_clr = 0, usr_cnt_load = 0;
  logic [3:0]  usr_ram_addr = 0, usr_ram_raddr = 0, usr_ram_wdata = 0, usr_ram_rdata;
  logic [1:0]  usr_f6_sel, usr_f6, usr_ram_rdata2, cnt, x, y;
  logic        usr_f7_sel, usr_f8_sel, usr_f7_ext, usr_f7, usr_f8, usr_cin, usr_cout;
  logic        usr_ram_we = 0, err;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  plsc_cluster plsc_cluster_i (.*);
  plsc_fabric_model plsc_fabric_model_i (.*);
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 2000) begin error_cnt++; stop_test(); end
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic luts(input int n);
    for (int k = 0; k < n; k++) begin
      tt[k] = $urandom;
      apb(1, 8'h08 + 8'(4 * k), {16'h0, tt[k]});
    end
  endtask
  initial begin
    void'($urandom(32'h9A1E));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    luts(8);
    apb(1, `PLSC_OFS_ARITH, 32'h0000_0880);
    apb(1, `PLSC_OFS_MODE, 32'h0001_0050);
    apb(1, `PLSC_OFS_LUT0, ~tt[0]);
    apb(0, `PLSC_OFS_LUT0, 0); chk(rd, {16'h0, tt[0]});
    apb(0, 8'h2C, 0); chk(err, 1);
    chk(rd, 0);
    repeat (200) begin
      @(posedge pclk); #1;
      for (int k = 0; k < 4; k++) chk(usr_f[k], tt[k][usr_lut_in[4*k+:4]]);
      {x, y} = {usr_arith_a[5:4], usr_arith_b[5:4]};
      y = usr_addsub[2] ? ~y : y;
      chk(usr_arith_s[5:4], 2'(x + y + usr_cin));
      {x, y} = {usr_arith_a[7:6], usr_arith_b[7:6]};
      chk({usr_ge[3], usr_ne[3], usr_le[3]}, {x >= y, x != y, x <= y});
    end
    presetn <= 0;
    @(posedge pclk) presetn <= 1;
    apb(0, `PLSC_OFS_LUT0, 0); chk(rd, 0);
    apb(1, `PLSC_OFS_MODE, 32'h0000_00AA);
    apb(0, `PLSC_OFS_MODE, 0); chk(rd, 32'h0000_002A);
    luts(4);
    apb(1, `PLSC_OFS_ARITH, 32'h0000_0600);
    apb(1, `PLSC_OFS_MODE, 32'h0001_006A);
    for (int a = 0; a < 16; a++) mem[a] = {tt[3][a], tt[2][a], tt[1][a], tt[0][a]};
    cnt = 0;
    repeat (300) begin
      @(posedge pclk);
      if (usr_ram_we) mem[usr_ram_addr] = usr_ram_wdata;
      if (usr_cnt_clr[3]) cnt = 0;
      else if (usr_cnt_load[3]) cnt = usr_arith_a[7:6];
      else if (usr_cnt_en[3]) cnt = usr_cnt_up[3] ? cnt + 1 : cnt - 1;
      {usr_ram_we, usr_ram_addr, usr_ram_raddr, usr_ram_wdata} <= 13'($urandom);
      {usr_cnt_en, usr_cnt_up, usr_cnt_load} <= 12'($urandom);
      usr_cnt_clr <= {$urandom % 8 == 0, 3'h0};
      #1;
      if (usr_cnt_clr[3]) cnt = 0;
      chk(usr_ram_rdata, mem[usr_ram_addr]);
      chk(usr_arith_s[7:6], cnt);
    end
    presetn <= 0;
    @(posedge pclk) presetn <= 1;
    luts(4);
    apb(1, `PLSC_OFS_ARITH, 32'h0000_8A00);
    apb(1, `PLSC_OFS_MODE, 32'h0001_016A);
    for (int a = 0; a < 16; a++) mem[a] = {tt[3][a], tt[2][a], tt[1][a], tt[0][a]};
    repeat (150) begin
      @(posedge pclk);
      if (usr_ram_we) mem[usr_ram_addr] = {usr_ram_wdata[1:0], usr_ram_wdata[1:0]};
      {usr_ram_we, usr_ram_addr, usr_ram_raddr, usr_ram_wdata} <= 13'($urandom);
      #1;
      chk(usr_ram_rdata, {2'h0, mem[usr_ram_addr][1:0]});
      chk(usr_ram_rdata2, mem[usr_ram_raddr][3:2]);
      x = usr_arith_a[7:6] & {2{usr_addsub[3]}};
      y = usr_arith_b[7:6];
      chk(usr_arith_s[7:6], 2'(x + y + usr_cin));
      chk(usr_cout, 3'(x + y + usr_cin) > 3);
      chk({usr_cg[3], usr_cp[3]}, {3'(x + y) > 3, 3'(x + y) == 3});
    end
    stop_test();
  end
endmodule // plsc_cluster_tb
